// ### inc/olps_pkg.sv
// Constants, types and map of the one-time area block.
// Assumes a single 20 MHz bus clock and byte indices of 10 bits.
package olps_pkg;

  // ********************************
  // Map (register index, byte addr = 4 x index)
  // ********************************
  localparam int          IDX_W            = 10;
  localparam logic [9:0]  IDX_ARRAY_LAST   = 10'h0FF;
  localparam logic [9:0]  IDX_SN_LOCK      = 10'h100;
  localparam logic [9:0]  IDX_FSB_FIRST    = 10'h102;
  localparam logic [9:0]  IDX_FSB_LAST     = 10'h109;
  localparam logic [9:0]  IDX_SSB_FIRST    = 10'h10A;
  localparam logic [9:0]  IDX_SSB_LAST     = 10'h111;
  localparam logic [9:0]  IDX_RL_LOW_A     = 10'h112;
  localparam logic [9:0]  IDX_RL_LOW_B     = 10'h113;
  localparam logic [9:0]  IDX_LOW_FIRST    = 10'h114;
  localparam logic [9:0]  IDX_LOW_LAST     = 10'h213;
  localparam logic [9:0]  IDX_RL_HIGH_A    = 10'h214;
  localparam logic [9:0]  IDX_RL_HIGH_B    = 10'h215;
  localparam logic [9:0]  IDX_UP_FIRST     = 10'h216;
  localparam logic [9:0]  IDX_OTP_LAST     = 10'h2FF;
  localparam logic [9:0]  IDX_STATUS       = 10'h300;
  localparam logic [9:0]  IDX_CONFIG       = 10'h301;
  localparam logic [9:0]  IDX_CONTROL      = 10'h302;
  localparam int          MEM_DEPTH        = 768;
  localparam int          REGION_SHIFT     = 4;

  // ********************************
  // Fields and values after reset
  // ********************************
  localparam logic [7:0]  SN_LOCK_PROG_MASK = 8'h03;
  localparam logic [7:0]  HIGH_B_PROG_MASK  = 8'h7F;
  localparam logic [7:0]  SN_LOCK_RESET     = 8'h01;
  localparam logic [7:0]  RL_RESET          = 8'h00;
  localparam logic [7:0]  CONFIG_RESET      = 8'h00;
  localparam logic [7:0]  ERASED_BYTE       = 8'hFF;
  localparam int          ST_READY_BIT      = 0;
  localparam int          ST_WEL_BIT        = 1;
  localparam int          ST_REJECT_BIT     = 2;
  localparam int          CTL_SET_WEL_BIT   = 0;
  localparam int          CTL_CLR_WEL_BIT   = 1;
  localparam int          CTL_CLR_REJ_BIT   = 2;
  localparam int          CFG_LOCK_PROG_BIT = 0;

  // ********************************
  // Timing
  // ********************************
  localparam int POWERUP_WAIT_US  = 300;
  localparam int CLK_KHZ          = 20000;
  localparam int POWERUP_WAIT_CYC = (POWERUP_WAIT_US * CLK_KHZ + 999) / 1000;

  // ********************************
  // Bus codes and types
  // ********************************
  localparam logic        HRESP_OKAY = 1'b0;

  typedef struct packed {
    logic       vld;
    logic       wr;
    logic       off_map;
    logic [9:0] idx;
  } olps_req_t;

  typedef enum logic [1:0] {
    OLPS_OFF     = 2'b00,
    OLPS_WAIT    = 2'b01,
    OLPS_STANDBY = 2'b10
  } olps_pwr_t;

endpackage

// ### logic/olps_powerup.sv
// Supply sense and power-up sequencing.
// Assumes supply_ok_pin is asynchronous to hclk.
`timescale 1ns/10ps
module olps_powerup #(
  parameter int WAIT_CYC = olps_pkg::POWERUP_WAIT_CYC
) (
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Supply sense
  input  wire logic supply_ok_pin,
  output logic      supply_ok,
  output logic      ready
);
  import olps_pkg::*;

  localparam int CW = $clog2(WAIT_CYC + 1);

  logic            sync1_ff;
  logic            sync2_ff;
  olps_pwr_t       state_ff;
  olps_pwr_t       nxt_state;
  logic [CW-1:0]   cnt_ff;

  // ********************************
  // Synchroniser
  // ********************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
    end else begin
      sync1_ff <= supply_ok_pin;
      sync2_ff <= sync1_ff;
    end
  end

  // ********************************
  // Sequencer
  // ********************************
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      OLPS_OFF:     if (sync2_ff) nxt_state = OLPS_WAIT;
      OLPS_WAIT:    if (cnt_ff == CW'(WAIT_CYC - 1)) nxt_state = OLPS_STANDBY;
      OLPS_STANDBY: nxt_state = OLPS_STANDBY;
      default:      nxt_state = OLPS_OFF;
    endcase
    if (!sync2_ff) nxt_state = OLPS_OFF;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) state_ff <= OLPS_OFF;
    else          state_ff <= nxt_state;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)                  cnt_ff <= '0;
    else if (state_ff == OLPS_WAIT) cnt_ff <= cnt_ff + CW'(1);
    else                           cnt_ff <= '0;
  end

  assign supply_ok = sync2_ff;
  assign ready     = (state_ff == OLPS_STANDBY);

endmodule

// ### logic/olps_otp_mem.sv
// Byte store of the one-time area, shipped contents loaded by reset.
// Assumes one read and one write port on the same clock.
`timescale 1ns/10ps
module olps_otp_mem #(
  parameter int          DEPTH          = olps_pkg::MEM_DEPTH,
  parameter logic [63:0] FACTORY_SERIAL = 64'h5A3C_9E17_C4D2_0B68
) (
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Read port
  input  wire logic [9:0] rd_idx,
  output logic      [7:0] rd_data,
  // Write port
  input  wire logic       wr_en,
  input  wire logic [9:0] wr_idx,
  input  wire logic [7:0] wr_data
);
  import olps_pkg::*;

  logic [7:0] mem_ff [DEPTH];
  logic [7:0] rd_ff;

  function automatic logic [7:0] shipped_byte(input int i);
    logic [9:0] off;
    off = 10'(i) - IDX_FSB_FIRST;
    if (10'(i) >= IDX_FSB_FIRST && 10'(i) <= IDX_FSB_LAST)
      shipped_byte = FACTORY_SERIAL[off[2:0]*8 +: 8];
    else
      shipped_byte = ERASED_BYTE;
  endfunction

  // ********************************
  // Storage
  // ********************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_ff[i] <= shipped_byte(i);
      end
    end else if (wr_en) begin
      mem_ff[wr_idx] <= wr_data;
    end
  end

  // Bypass keeps a read right after a program current
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)                         rd_ff <= ERASED_BYTE;
    else if (wr_en && wr_idx == rd_idx)   rd_ff <= wr_data;
    else                                  rd_ff <= mem_ff[rd_idx];
  end

  assign rd_data = rd_ff;

endmodule

// ### logic/olps_top.sv
// One-time area with lock bytes and power-up gating, AHB-Lite slave.
// Assumes a single AHB-Lite master, word transfers, one 20 MHz clock.
//
// Notes on behaviour
// - Serial lock bit 0 guards first serial block, bit 1 the second.
// - Serial lock bits 2 to 7 never program; attempts are ignored.
// - Bit 7 of upper second lock byte never programs.
// - Each region lock bit guards one 16-byte region, lowest bit first.
// - Last region is 10 bytes ending at top; others 16 bytes.
// - Power-up lands in standby with write enable latch cleared.
// - Below supply threshold nothing operates and no command answers.
// - Main array reads all ones as shipped.
// - Status and configuration registers read zero as shipped.
// - Serial lock byte ships as 0x01, first serial block locked.
// - First serial block ships holding a unique 64-bit number.
//
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module olps_top #(
  parameter int          POWERUP_WAIT_CYC = olps_pkg::POWERUP_WAIT_CYC,
  parameter logic [63:0] FACTORY_SERIAL   = 64'h5A3C_9E17_C4D2_0B68
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Supply sense and state
  input  wire logic        supply_ok_pin,
  output logic             device_ready
);
  import olps_pkg::*;

  // ********************************
  // Declarations
  // ********************************
  olps_req_t  req_ff;
  olps_req_t  nxt_req;
  logic       take;
  logic       supply_ok;
  logic       ready;
  logic [7:0] mem_rdata;
  logic       mem_wr;
  logic [7:0] mem_wdata;
  logic [7:0] sn_lock_ff;
  logic [7:0] rl_low_a_ff;
  logic [7:0] rl_low_b_ff;
  logic [7:0] rl_high_a_ff;
  logic [7:0] rl_high_b_ff;
  logic [7:0] config_ff;
  logic       wel_ff;
  logic       reject_ff;
  logic [7:0] wbyte;
  logic       wr_phase;
  logic       is_data;
  logic       is_lock;
  logic       locked;
  logic       prog_try;
  logic       prog_ok;
  logic       lock_ok;
  logic       ctl_wr;
  logic       cfg_wr;
  logic [7:0] status_b;
  logic [7:0] rd_byte;

  // ********************************
  // Decode helpers
  // ********************************
  function automatic logic in_rng(input logic [9:0] i,
                                  input logic [9:0] lo,
                                  input logic [9:0] hi);
    in_rng = (i >= lo) && (i <= hi);
  endfunction

  // Programmable data byte of the one-time area
  function automatic logic data_byte(input logic [9:0] i);
    data_byte = in_rng(i, IDX_FSB_FIRST, IDX_SSB_LAST)
              | in_rng(i, IDX_LOW_FIRST, IDX_LOW_LAST)
              | in_rng(i, IDX_UP_FIRST, IDX_OTP_LAST);
  endfunction

  function automatic logic lock_byte(input logic [9:0] i);
    lock_byte = (i == IDX_SN_LOCK)  | (i == IDX_RL_LOW_A)
              | (i == IDX_RL_LOW_B) | (i == IDX_RL_HIGH_A)
              | (i == IDX_RL_HIGH_B);
  endfunction

  function automatic logic lock_of(input logic [9:0]  i,
                                   input logic [7:0]  sn,
                                   input logic [15:0] lo,
                                   input logic [15:0] hi);
    logic [9:0] off;
    off     = '0;
    lock_of = 1'b0;
    if (in_rng(i, IDX_FSB_FIRST, IDX_FSB_LAST)) begin
      lock_of = sn[0];
    end else if (in_rng(i, IDX_SSB_FIRST, IDX_SSB_LAST)) begin
      lock_of = sn[1];
    end else if (in_rng(i, IDX_LOW_FIRST, IDX_LOW_LAST)) begin
      off     = i - IDX_LOW_FIRST;
      lock_of = lo[off[REGION_SHIFT +: 4]];
    end else if (in_rng(i, IDX_UP_FIRST, IDX_OTP_LAST)) begin
      off     = i - IDX_UP_FIRST;
      lock_of = hi[off[REGION_SHIFT +: 4]];
    end
  endfunction

  // ********************************
  // Power-up sequencing
  // ********************************
  olps_powerup #(
    .WAIT_CYC      (POWERUP_WAIT_CYC)
  ) u_pwr (
    .hclk          (hclk),
    .hresetn       (hresetn),
    .supply_ok_pin (supply_ok_pin),
    .supply_ok     (supply_ok),
    .ready         (ready)
  );

  assign device_ready = ready;

  // ********************************
  // Bus address phase
  // ********************************
  assign take = hsel & hready & htrans[1];

  always_comb begin
    nxt_req         = '0;
    nxt_req.vld     = take;
    nxt_req.wr      = hwrite;
    nxt_req.off_map = |haddr[31:12];
    nxt_req.idx     = haddr[11:2];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)    req_ff <= '0;
    else if (hready) req_ff <= nxt_req;
  end

  // Zero wait states, so every transfer is answered OKAY at once
  assign hreadyout = 1'b1;
  assign hresp     = HRESP_OKAY;

  // ********************************
  // Byte store
  // ********************************
  olps_otp_mem #(
    .DEPTH          (MEM_DEPTH),
    .FACTORY_SERIAL (FACTORY_SERIAL)
  ) u_mem (
    .hclk           (hclk),
    .hresetn        (hresetn),
    .rd_idx         (haddr[11:2]),
    .rd_data        (mem_rdata),
    .wr_en          (mem_wr),
    .wr_idx         (req_ff.idx),
    .wr_data        (mem_wdata)
  );

  // ********************************
  // Program decode (data phase)
  // ********************************
  assign wbyte    = hwdata[7:0];
  assign wr_phase = req_ff.vld & req_ff.wr & ~req_ff.off_map;
  assign is_data  = data_byte(req_ff.idx);
  assign is_lock  = lock_byte(req_ff.idx);
  assign locked   = lock_of(req_ff.idx, sn_lock_ff,
                            {rl_low_b_ff, rl_low_a_ff},
                            {rl_high_b_ff, rl_high_a_ff});

  assign prog_try = wr_phase & ready & (is_data | is_lock);
  assign prog_ok  = prog_try & is_data & wel_ff & ~locked;
  assign lock_ok  = prog_try & is_lock & wel_ff
                  & config_ff[CFG_LOCK_PROG_BIT];
  assign ctl_wr   = wr_phase & ready & (req_ff.idx == IDX_CONTROL);
  assign cfg_wr   = wr_phase & ready & (req_ff.idx == IDX_CONFIG);

  // One-time bits only go from one to zero
  assign mem_wr    = prog_ok;
  assign mem_wdata = mem_rdata & wbyte;

  // ********************************
  // Lock bytes
  // ********************************
  // Lock bits only ever set, so a lock can never be undone
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sn_lock_ff <= SN_LOCK_RESET;
    end else if (lock_ok && req_ff.idx == IDX_SN_LOCK) begin
      sn_lock_ff <= sn_lock_ff | (wbyte & SN_LOCK_PROG_MASK);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rl_low_a_ff <= RL_RESET;
      rl_low_b_ff <= RL_RESET;
    end else if (lock_ok) begin
      if (req_ff.idx == IDX_RL_LOW_A) rl_low_a_ff <= rl_low_a_ff | wbyte;
      if (req_ff.idx == IDX_RL_LOW_B) rl_low_b_ff <= rl_low_b_ff | wbyte;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rl_high_a_ff <= RL_RESET;
      rl_high_b_ff <= RL_RESET;
    end else if (lock_ok) begin
      if (req_ff.idx == IDX_RL_HIGH_A) rl_high_a_ff <= rl_high_a_ff | wbyte;
      if (req_ff.idx == IDX_RL_HIGH_B) begin
        rl_high_b_ff <= rl_high_b_ff | (wbyte & HIGH_B_PROG_MASK);
      end
    end
  end

  // ********************************
  // Control, status, configuration
  // ********************************
  // Configuration ships zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)    config_ff <= CONFIG_RESET;
    else if (cfg_wr) config_ff <= wbyte;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wel_ff <= 1'b0;
    end else if (!ready) begin
      wel_ff <= 1'b0;
    end else if (prog_try) begin
      // Each program attempt spends the latch
      wel_ff <= 1'b0;
    end else if (ctl_wr) begin
      if (wbyte[CTL_SET_WEL_BIT])      wel_ff <= 1'b1;
      else if (wbyte[CTL_CLR_WEL_BIT]) wel_ff <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reject_ff <= 1'b0;
    end else if (prog_try && !prog_ok && !lock_ok) begin
      reject_ff <= 1'b1;
    end else if (ctl_wr && wbyte[CTL_CLR_REJ_BIT]) begin
      reject_ff <= 1'b0;
    end
  end

  always_comb begin
    status_b                = '0;
    status_b[ST_READY_BIT]  = ready;
    status_b[ST_WEL_BIT]    = wel_ff;
    status_b[ST_REJECT_BIT] = reject_ff;
  end

  // ********************************
  // Read data (data phase)
  // ********************************
  always_comb begin
    rd_byte = '0;
    if (req_ff.off_map) begin
      rd_byte = '0;
    end else if (req_ff.idx <= IDX_ARRAY_LAST) begin
      rd_byte = ERASED_BYTE;
    end else if (req_ff.idx <= IDX_OTP_LAST) begin
      case (req_ff.idx)
        IDX_SN_LOCK:   rd_byte = sn_lock_ff;
        IDX_RL_LOW_A:  rd_byte = rl_low_a_ff;
        IDX_RL_LOW_B:  rd_byte = rl_low_b_ff;
        IDX_RL_HIGH_A: rd_byte = rl_high_a_ff;
        IDX_RL_HIGH_B: rd_byte = rl_high_b_ff;
        default:       rd_byte = mem_rdata;
      endcase
    end else begin
      case (req_ff.idx)
        IDX_STATUS: rd_byte = status_b;
        IDX_CONFIG: rd_byte = config_ff;
        default:    rd_byte = '0;
      endcase
    end
  end

  assign hrdata = (req_ff.vld & supply_ok) ? {24'h000000, rd_byte}
                                           : 32'h00000000;

endmodule

// ### verification/olps_props.sv
// Checker of the one-time area block, bound to olps_top.
// Assumes hready is fed from hreadyout and word transfers only.
`timescale 1ns/10ps
module olps_props #(
  parameter int POWERUP_WAIT_CYC = olps_pkg::POWERUP_WAIT_CYC
) (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Supply
  input wire logic        supply_ok_pin,
  input wire logic        device_ready
);
  import olps_pkg::*;
  logic       rd_dp_ff;
  logic [9:0] idx_ff;
  int         hi_cnt_ff;
  int         lo_cnt_ff;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ****************
  // Helper logic
  // ****************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_dp_ff <= 1'b0;
      idx_ff   <= 10'h000;
    end else begin
      rd_dp_ff <= hsel & hready & htrans[1] & !hwrite
                  & (haddr[31:12] == 20'h00000);
      idx_ff   <= haddr[11:2];
    end
  end

  // Counts from release, as the design does
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hi_cnt_ff <= 0;
      lo_cnt_ff <= 0;
    end else begin
      hi_cnt_ff <= supply_ok_pin ? hi_cnt_ff + 1 : 0;
      lo_cnt_ff <= supply_ok_pin ? 0 : lo_cnt_ff + 1;
    end
  end

  // ****************
  // Assertions
  // ****************
  a_bus_okay: assert property (hresp == HRESP_OKAY && hreadyout)
    else $error("bus answer not okay");
  a_upper_zero: assert property (rd_dp_ff |-> hrdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  a_wait_time: assert property ($rose(device_ready) |->
    hi_cnt_ff >= POWERUP_WAIT_CYC && hi_cnt_ff <= POWERUP_WAIT_CYC + 4)
    else $error("device ready at wrong time");
  a_ready_falls: assert property (lo_cnt_ff >= 4 |-> !device_ready)
    else $error("ready while supply low");
  a_nosupply_rd: assert property (
    rd_dp_ff && lo_cnt_ff >= 4 |-> hrdata == 32'h00000000)
    else $error("read answered without supply");
  a_array_ones: assert property (
    rd_dp_ff && idx_ff <= IDX_ARRAY_LAST && hi_cnt_ff >= 4
    |-> hrdata == 32'h000000FF)
    else $error("main array not all ones");
  a_sn_mask: assert property (
    rd_dp_ff && idx_ff == IDX_SN_LOCK |-> hrdata[7:2] == 6'h00)
    else $error("serial lock upper bits set");
  a_hb_mask: assert property (
    rd_dp_ff && idx_ff == IDX_RL_HIGH_B |-> !hrdata[7])
    else $error("upper lock bit seven set");

  c_ready: cover property ($rose(device_ready));
  c_low_rd: cover property (rd_dp_ff && lo_cnt_ff >= 4);
  c_hb_rd: cover property (rd_dp_ff && idx_ff == IDX_RL_HIGH_B);
endmodule

bind olps_top olps_props #(.POWERUP_WAIT_CYC(POWERUP_WAIT_CYC)) props_u (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .supply_ok_pin(supply_ok_pin),
  .device_ready(device_ready));

// ### verification/olps_host.sv
// Bus master model standing in for the host.
// Assumes one slave whose hreadyout is the bus hready.
`timescale 1ns/10ps
module olps_host (
  // Clock and answer
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  // Request
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata
);
  initial begin
    hsel   = 1'b1;
    haddr  = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h00000000;
  end

  // Single word transfer; stale write data is inverted, never left valid
  task automatic xfer(input logic wr, input logic [31:0] addr,
                      input logic [7:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    haddr  <= addr;
    htrans <= 2'b10;
    hwrite <= wr;
    hwdata <= ~hwdata;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {24'h000000, wd};
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
endmodule

// ### verification/testbench.sv
// Self-checking bench of the one-time area block.
// Assumes olps_top, olps_host and the bound checker are compiled.
`timescale 1ns/10ps
module testbench;
  import olps_pkg::*;
  localparam int          WAIT   = 200;
  // Arbitrary serial value
  localparam logic [63:0] SERIAL = 64'h1122_3344_5566_7788;
  logic        hclk, hresetn, supply_ok_pin, device_ready;
  logic        hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  int          mismatches;
  int          n_checks;

  olps_top #(.POWERUP_WAIT_CYC(WAIT), .FACTORY_SERIAL(SERIAL)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .supply_ok_pin(supply_ok_pin),
    .device_ready(device_ready));
  olps_host host_u (
    .hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata));

  initial hclk = 1'b0;
  always #25 hclk = ~hclk;

  // ****************
  // Shared tasks
  // ****************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    logic [31:0] r;
    host_u.xfer(1'b1, {20'h00000, idx, 2'b00}, d, r);
  endtask
  task automatic rdc(input logic [9:0] idx, input logic [7:0] e);
    logic [31:0] v;
    host_u.xfer(1'b0, {20'h00000, idx, 2'b00}, 8'h00, v);
    chk(v, {24'h000000, e});
  endtask
  // Every program needs the latch set first
  task automatic prog(input logic [9:0] idx, input logic [7:0] d);
    wr(IDX_CONTROL, 8'h01);
    wr(idx, d);
  endtask
  task automatic end_of_test();
    $display("Counts: mismatches %0d checks %0d", mismatches, n_checks);
    if (mismatches == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ****************
  // Scenarios
  // ****************
  task automatic t_shipped();
    logic [31:0] v;
    rdc(10'h000, 8'hFF);
    rdc(IDX_ARRAY_LAST, 8'hFF);
    rdc(IDX_STATUS, 8'h00);
    rdc(IDX_CONFIG, 8'h00);
    rdc(IDX_SN_LOCK, 8'h01);
    for (int i = 0; i < 8; i++) begin
      rdc(IDX_FSB_FIRST + 10'(i), SERIAL[8*i +: 8]);
    end
    host_u.xfer(1'b0, 32'h00001000, 8'h00, v);
    chk(v, 32'h00000000);
    wr(IDX_CONFIG, 8'h01);
    rdc(IDX_CONFIG, 8'h00);
  endtask

  task automatic t_powerup();
    int n;
    n = 0;
    // no program traffic before the wait ends
    while (device_ready !== 1'b1 && n < 1000) begin
      @(posedge hclk);
      n++;
    end
    rdc(IDX_STATUS, 8'h01);
  endtask

  task automatic t_masks();
    // Lock bytes refused while configuration bit is clear
    prog(IDX_RL_LOW_B, 8'h01);
    rdc(IDX_RL_LOW_B, 8'h00);
    wr(IDX_CONTROL, 8'h01);
    rdc(IDX_STATUS, 8'h07);
    wr(IDX_CONTROL, 8'h02);
    rdc(IDX_STATUS, 8'h05);
    wr(IDX_CONFIG, 8'h01);
    prog(IDX_SSB_FIRST, 8'h5A);
    rdc(IDX_SSB_FIRST, 8'h5A);
    prog(IDX_FSB_FIRST, 8'h00);
    rdc(IDX_FSB_FIRST, SERIAL[7:0]);
    rdc(IDX_STATUS, 8'h05);
    wr(IDX_CONTROL, 8'h04);
    prog(IDX_SN_LOCK, 8'hFE);
    rdc(IDX_SN_LOCK, 8'h03);
    prog(IDX_SSB_FIRST, 8'h00);
    rdc(IDX_SSB_FIRST, 8'h5A);
    prog(IDX_RL_HIGH_B, 8'h80);
    rdc(IDX_RL_HIGH_B, 8'h00);
    wr(IDX_CONTROL, 8'h04);
  endtask

  // Edge regions of the low and high lock pairs, top region last
  task automatic t_regions();
    int         rg[5] = '{1, 16, 17, 30, 31};
    int         j;
    logic [9:0] lk, fst, lst;
    foreach (rg[k]) begin
      j   = (rg[k] > 16) ? rg[k] - 17 : rg[k] - 1;
      lk  = ((rg[k] > 16) ? 10'h214 : 10'h112) + 10'(j / 8);
      fst = ((rg[k] > 16) ? 10'h216 : 10'h114) + 10'(16 * j);
      lst = fst + ((rg[k] == 31) ? 10'h009 : 10'h00F);
      prog(lst, 8'hA5);
      rdc(lst, 8'hA5);
      prog(lk, 8'(1 << (j % 8)));
      prog(fst, 8'h00);
      rdc(fst, (rg[k] == 31) ? 8'h3C : 8'hFF);
      prog(lst, 8'h00);
      rdc(lst, 8'hA5);
      if (rg[k] != 16 && rg[k] != 31) begin
        prog(lst + 10'h001, 8'h3C);
        rdc(lst + 10'h001, 8'h3C);
      end
      wr(IDX_CONTROL, 8'h04);
    end
  endtask

  task automatic t_supply();
    // Latch left set so its clearing at power-up shows
    wr(IDX_CONTROL, 8'h01);
    rdc(IDX_STATUS, 8'h03);
    supply_ok_pin <= 1'b0;
    repeat (6) @(posedge hclk);
    chk({31'h0, device_ready}, 32'h00000000);
    rdc(IDX_FSB_FIRST, 8'h00);
    prog(10'h124, 8'h00);
    supply_ok_pin <= 1'b1;
    t_powerup();
    rdc(10'h124, 8'h3C);
  endtask

  initial begin
    mismatches    = 0;
    n_checks      = 0;
    hresetn       = 1'b0;
    supply_ok_pin = 1'b1;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_shipped();
    t_powerup();
    t_masks();
    t_regions();
    t_supply();
    end_of_test();
  end

  // Far beyond the several hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge hclk);
    mismatches++;
    end_of_test();
  end
endmodule
